// >>> ctm_channel.v
// Channel transfer module: takes bus input commands, stores link bytes in memory, then acknowledges.
//
// Notes on behaviour
// - When an accepted command has been carried out the module sends an acknowledge over the bus.
// - The module takes only commands whose channel number is its own and ignores the rest.
// - For input the module stores exactly the requested bytes at ascending addresses from the pointer.
// - When the stored count reaches the size the module returns an acknowledge with its channel number.
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.vh"
module ctm_channel (
  input  wire                   clk_in,
  input  wire                   rst_b_in,
  input  wire                   cmd_valid_in,
  output reg                    cmd_ready_out,
  input  wire [`CTM_CHAN_W-1:0] cmd_chan_in,
  input  wire [`CTM_CMD_W-1:0]  cmd_code_in,
  input  wire [`CTM_ADDR_W-1:0] cmd_ptr_in,
  input  wire [`CTM_CNT_W-1:0]  cmd_count_in,
  input  wire                   link_valid_in,
  input  wire [`CTM_DATA_W-1:0] link_data_in,
  output reg                    link_ready_out,
  output reg                    mem_we_out,
  output reg  [`CTM_ADDR_W-1:0] mem_addr_out,
  output reg  [`CTM_DATA_W-1:0] mem_data_out,
  output reg                    ack_valid_out,
  output reg  [`CTM_CMD_W-1:0]  ack_code_out,
  output reg  [`CTM_CHAN_W-1:0] ack_chan_out,
  output reg                    busy_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_MOVE = 2'h1;
  localparam ST_ACK  = 2'h2;

  // The link pins are outside the clock domain, so they pass two flops first.
  reg                   lv_s1_r;
  reg                   lv_s2_r;
  reg [`CTM_DATA_W-1:0] ld_s1_r;
  reg [`CTM_DATA_W-1:0] ld_s2_r;
  reg                   lv_prev_r;
  reg [1:0]             state_r;
  reg [1:0]             state_nxt;
  reg [`CTM_ADDR_W-1:0] ptr_r;
  reg [`CTM_CNT_W-1:0]  left_r;
  wire                  link_strobe;
  wire                  f_ready;
  wire                  f_valid;
  wire [`CTM_DATA_W-1:0] f_data;
  wire                  take_cmd;
  wire                  pop;

  function own_chan;
    input [`CTM_CHAN_W-1:0] ch;
    begin
      own_chan = (ch == `CTM_CHAN_OWN);
    end
  endfunction

  // A byte arrives on each rising edge of the synchronised valid level.
  assign link_strobe = lv_s2_r & ~lv_prev_r;

  // Foreign channels and non-input codes are never accepted, so they wait for their own module.
  assign take_cmd = (state_r == ST_IDLE) && cmd_valid_in && own_chan(cmd_chan_in) &&
                    (cmd_code_in == `CTM_CMD_INPUT);
  assign pop = (state_r == ST_MOVE) && f_valid && (left_r != {`CTM_CNT_W{1'b0}});

  ctm_fifo #(
    .WIDTH (`CTM_DATA_W),
    .DEPTH (`CTM_FIFO_DEPTH),
    .AW    (`CTM_FIFO_AW)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .wr_valid_in  (link_strobe),
    .wr_ready_out (f_ready),
    .wr_data_in   (ld_s2_r),
    .rd_valid_out (f_valid),
    .rd_ready_in  (pop),
    .rd_data_out  (f_data)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take_cmd) begin
          state_nxt = (cmd_count_in == {`CTM_CNT_W{1'b0}}) ? ST_ACK : ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (pop && left_r == {{(`CTM_CNT_W-1){1'b0}}, 1'b1}) begin
          state_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      lv_s1_r        <= 1'b0;
      lv_s2_r        <= 1'b0;
      ld_s1_r        <= {`CTM_DATA_W{1'b0}};
      ld_s2_r        <= {`CTM_DATA_W{1'b0}};
      lv_prev_r      <= 1'b0;
      state_r        <= ST_IDLE;
      ptr_r          <= {`CTM_ADDR_W{1'b0}};
      left_r         <= {`CTM_CNT_W{1'b0}};
      cmd_ready_out  <= 1'b0;
      link_ready_out <= 1'b0;
      mem_we_out     <= 1'b0;
      mem_addr_out   <= {`CTM_ADDR_W{1'b0}};
      mem_data_out   <= {`CTM_DATA_W{1'b0}};
      ack_valid_out  <= 1'b0;
      ack_code_out   <= {`CTM_CMD_W{1'b0}};
      ack_chan_out   <= {`CTM_CHAN_W{1'b0}};
      busy_out       <= 1'b0;
    end else begin
      lv_s1_r        <= link_valid_in;
      lv_s2_r        <= lv_s1_r;
      ld_s1_r        <= link_data_in;
      ld_s2_r        <= ld_s1_r;
      lv_prev_r      <= lv_s2_r;
      state_r        <= state_nxt;
      cmd_ready_out  <= take_cmd;
      // Ready is dropped with margin for the two sync stages still in flight.
      link_ready_out <= f_ready && !(link_strobe || lv_s1_r);
      mem_we_out     <= pop;
      ack_valid_out  <= 1'b0;
      if (take_cmd) begin
        ptr_r  <= cmd_ptr_in;
        left_r <= cmd_count_in;
      end
      if (pop) begin
        mem_addr_out <= ptr_r;
        mem_data_out <= f_data;
        ptr_r        <= ptr_r + {{(`CTM_ADDR_W-1){1'b0}}, 1'b1};
        left_r       <= left_r - {{(`CTM_CNT_W-1){1'b0}}, 1'b1};
      end
      if (state_r == ST_ACK) begin
        ack_valid_out <= 1'b1;
        ack_code_out  <= `CTM_CMD_ACK;
        ack_chan_out  <= `CTM_CHAN_OWN;
      end
      busy_out <= (state_nxt != ST_IDLE);
    end
  end
endmodule
`default_nettype wire

// >>> ctm_consts.vh
// Constants for the channel transfer module.
`ifndef CTM_CONSTS_VH
`define CTM_CONSTS_VH
`define CTM_CHAN_W        4
`define CTM_CMD_W         2
`define CTM_ADDR_W        32
`define CTM_CNT_W         16
`define CTM_DATA_W        8
`define CTM_CMD_INPUT     2'h1
`define CTM_CMD_ACK       2'h3
`define CTM_CHAN_OWN      4'h0
`define CTM_FIFO_DEPTH    8
`define CTM_FIFO_AW       3
`define CTM_CHAN_WORD     32'h8000_002C
`define CTM_TASK_BASE     32'h0000_0100
`endif

// >>> ctm_fifo.v
// Byte FIFO between the link input and the memory writer.
`timescale 1ns/10ps
`default_nettype none
module ctm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_in,
  input  wire             rst_b_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wptr_r;
  reg [AW-1:0]    rptr_r;
  reg [AW:0]      count_r;
  wire            do_wr;
  wire            do_rd;
  integer         i;

  assign wr_ready_out = (count_r != DEPTH[AW:0]);
  assign rd_valid_out = (count_r != {(AW+1){1'b0}});
  assign rd_data_out  = mem_r[rptr_r];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      wptr_r  <= {AW{1'b0}};
      rptr_r  <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (do_wr) begin
        mem_r[wptr_r] <= wr_data_in;
        wptr_r        <= wptr_r + 1'b1;
      end
      if (do_rd) begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> ctm_channel_assertions.sv
// Concurrent checks on the channel transfer module ports.
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.vh"
module ctm_channel_checker (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        cmd_valid_in,
  input wire logic        cmd_ready_out,
  input wire logic        busy_out,
  input wire logic        mem_we_out,
  input wire logic        ack_valid_out,
  input wire logic [3:0]  cmd_chan_in,
  input wire logic [3:0]  ack_chan_out,
  input wire logic [1:0]  cmd_code_in,
  input wire logic [1:0]  ack_code_out,
  input wire logic [31:0] cmd_ptr_in,
  input wire logic [31:0] mem_addr_out
);
  logic [31:0] next_addr_r;
  // The pointer is still held by the requester in the cycle that ready shows.
  always @(posedge clk_in) begin
    if (cmd_ready_out)
      next_addr_r <= cmd_ptr_in;
    else if (mem_we_out)
      next_addr_r <= next_addr_r + 32'h0000_0001;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_ack_done;
    (ack_valid_out && !busy_out) ##1 !ack_valid_out;
  endsequence
  a_ready_pulse: assert property (cmd_ready_out |=> !cmd_ready_out) else $error("ready too long");
  a_ready_cause: assert property (cmd_ready_out |-> $past(cmd_valid_in && !busy_out
    && cmd_chan_in == `CTM_CHAN_OWN && cmd_code_in == `CTM_CMD_INPUT)) else $error("bad accept");
  a_ready_busy: assert property (cmd_ready_out |-> busy_out) else $error("not busy");
  a_ack_fields: assert property (ack_valid_out |-> ack_chan_out == `CTM_CHAN_OWN
    && ack_code_out == `CTM_CMD_ACK) else $error("bad ack");
  a_ack_release: assert property (ack_valid_out |-> s_ack_done) else $error("ack end");
  a_hold_pending: assert property (busy_out && !ack_valid_out |=> !cmd_ready_out) else $error("overlap");
  a_write_busy: assert property (mem_we_out |-> busy_out && !ack_valid_out) else $error("stray write");
  a_addr_step: assert property (mem_we_out |-> mem_addr_out == next_addr_r) else $error("addr");
endmodule
`default_nettype wire

// >>> ctm_link_src.sv
// Link byte source standing in for the sending device.
`timescale 1ns/10ps
`default_nettype none
module ctm_link_src (
  input  wire logic       clk_in,
  input  wire logic       ready_in,
  output var  logic       valid_out,
  output var  logic [7:0] data_out
);
  initial begin
    valid_out = 1'b0;
    data_out = 8'h00;
  end
  // Data is inverted once its hold has run out, so a stale byte never passes for a good one.
  task automatic send(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      while (!ready_in) @(posedge clk_in);
      #2 data_out = b + i[7:0];
      @(posedge clk_in);
      #2 valid_out = 1'b1;
      repeat (2) @(posedge clk_in);
      #2 valid_out = 1'b0;
      repeat (2) @(posedge clk_in);
      #2 data_out = ~data_out;
    end
  endtask
endmodule
`default_nettype wire

// >>> channel_transfer_module_tb.sv
// Self-checking bench for the channel transfer module.
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.vh"
module channel_transfer_module_tb;
  logic        clk_in, rst_b_in, cmd_valid_in, cmd_ready_out, link_valid_in, link_ready_out;
  logic        mem_we_out, ack_valid_out, busy_out;
  logic [3:0]  cmd_chan_in, ack_chan_out;
  logic [1:0]  cmd_code_in, ack_code_out;
  logic [31:0] cmd_ptr_in, mem_addr_out;
  logic [15:0] cmd_count_in;
  logic [7:0]  link_data_in, mem_data_out;
  logic [7:0]  mem [256];
  int          miscompares, checks_done, cyc, acks, issued;
  logic [31:0] chan_addr, chan_word, requeued, last_len;
  logic [1:0]  last_code;
  ctm_channel dut (.*);
  ctm_link_src src (.clk_in, .ready_in(link_ready_out), .valid_out(link_valid_in), .data_out(link_data_in));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (mem_we_out) mem[mem_addr_out[7:0]] <= mem_data_out;
    if (ack_valid_out) acks <= acks + 1;
    if (ack_valid_out) requeued <= chan_word;
    if (cyc == 4000) begin
      miscompares++;
      test_done;
    end
  end
  task chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cmd(input logic [3:0] ch, input logic [1:0] cd, input logic [31:0] p, input logic [15:0] n, input logic take);
    int k;
    chan_addr = `CTM_CHAN_WORD;
    chan_word = `CTM_TASK_BASE + {28'h000_0000, ch};
    last_code = cd;
    last_len = {16'h0000, n};
    if (take) issued++;
    @(posedge clk_in);
    #2 {cmd_chan_in, cmd_code_in, cmd_ptr_in, cmd_count_in, cmd_valid_in} = {ch, cd, p, n, 1'b1};
    for (k = 0; k < 300 && cmd_ready_out !== 1'b1; k++) @(posedge clk_in) #1;
    chk(cmd_ready_out, take, "taken");
    @(posedge clk_in);
    #2 cmd_valid_in = 1'b0;
  endtask
  task wack(input int n);
    for (int k = 0; k < 300 && acks < n; k++) @(posedge clk_in) #1;
    chk(acks, n, "acks");
    chk(busy_out, 1'b0, "busy");
    chk(issued - acks, 0, "parked");
    chk(requeued, `CTM_TASK_BASE + `CTM_CHAN_OWN, "requeued");
    chk(last_code, `CTM_CMD_INPUT, "code");
  endtask
  task t_basic;
    fork
      src.send(3, 8'hA0);
      begin
        cmd(`CTM_CHAN_OWN, `CTM_CMD_INPUT, 32'h0000_0010, 16'h0003, 1'b1);
        cmd(`CTM_CHAN_OWN, `CTM_CMD_INPUT, 32'h0000_0030, 16'h0000, 1'b1);
      end
    join
    wack(2);
    for (int i = 0; i < 4; i++) chk(mem[8'h10 + i], i < 3 ? 8'hA0 + i : 8'h00, "byte");
    $display("test basic done");
  endtask
  task t_foreign;
    cmd(4'h5, `CTM_CMD_INPUT, 32'h0000_0050, 16'h0001, 1'b0);
    cmd(`CTM_CHAN_OWN, `CTM_CMD_ACK, 32'h0000_0050, 16'h0001, 1'b0);
    chk(busy_out, 1'b0, "idle");
    chk(link_ready_out, 1'b1, "link ready");
    $display("test foreign done");
  endtask
  task t_fifo;
    src.send(8, 8'h50);
    cmd(`CTM_CHAN_OWN, `CTM_CMD_INPUT, 32'h0000_0080, 16'h0008, 1'b1);
    wack(3);
    for (int i = 0; i < 8; i++) chk(mem[8'h80 + i], 8'h50 + i, "buffered");
    $display("test fifo done");
  endtask
  task test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {rst_b_in, cmd_valid_in, cmd_chan_in, cmd_code_in, cmd_ptr_in, cmd_count_in} = '0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (6) @(posedge clk_in);
    #2 rst_b_in = 1'b1;
    t_basic;
    t_foreign;
    t_fifo;
    test_done;
  end
endmodule
bind ctm_channel ctm_channel_checker chk_u (.*);
`default_nettype wire
